//--- core/irq_flag_bank.sv
// Interrupt request flag and enable register bank with vector request to the CPU core.
// Assumes the CPU core writes registers with a one-cycle strobe on the system clock,
// and acknowledges the presented vector with a one-cycle pulse when it takes it.
//
// Function
// - Pin edge code 00 disables, 01 rising edge, 10 falling edge.
// - Pin0 code at bits 1:0, pin1 code at bits 3:2; upper bits read zero.
// - Control 0 bit 0 is the global enable gating every interrupt.
// - Flags read 1 while pending; software writes set or clear them.
// - Per-source enable gates the interrupt; the flag still records.
// - Control 0: group0, pin1, pin0 flags at 6,5,4; enables at 3,2,1.
// - Control 1: timebase1/timebase0 flags at 7,6; enables at 3,2.
// - Control 1: conv-done flag 5 enable 1; group1 flag 4 enable 0.
// - Control 2: group2 flag 4 enable 0; large variant group3 flag 5 enable 1.
// - Group0 register: timer0 cmpa/cmpp flags at 5,4; enables at 1,0.
// - Group1: timer1 cmpa/cmpp at 5,4 and 1,0; cmpb at 6 and 2 when present.
// - Unimplemented bits read zero; all flags and enables reset to zero.
// - Interrupt taken only with flag, own enable and global enable all high.
// - Servicing clears the global enable; new requests still set flags.
// - Group flag sets when a member flag sets under its own enable; cleared on servicing.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_bank
   import irq_bank_pkg::*;
#(
   parameter int VARIANT = VAR_LARGE
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_pin0,
   input wire logic i_pin1,
   input wire logic i_timebase0_evt,
   input wire logic i_timebase1_evt,
   input wire logic i_conv_done_evt,
   input wire logic i_timer0_cmpp_evt,
   input wire logic i_timer0_cmpa_evt,
   input wire logic i_timer1_cmpp_evt,
   input wire logic i_timer1_cmpa_evt,
   input wire logic i_timer1_cmpb_evt,
   input wire logic i_undervolt_evt,
   input wire logic i_eeprom_evt,
   input wire logic i_timer2_cmpp_evt,
   input wire logic i_timer2_cmpa_evt,
   input wire logic i_stack_full,
   input wire logic i_irq_ack,
   output logic o_irq_req,
   output logic [3:0] o_irq_vector,
   output logic o_global_irq_enable
);

   // Implemented bits for the chosen variant
   localparam logic [NPRIM-1:0] PRIM_IMPL = (VARIANT == VAR_LARGE) ? PRIM_IMPL_LARGE : PRIM_IMPL_SMALL;
   localparam logic [NSRC-1:0] SRC_IMPL = (VARIANT == VAR_LARGE) ? SRC_IMPL_LARGE :
                                          (VARIANT == VAR_CMPB) ? SRC_IMPL_CMPB : SRC_IMPL_SMALL;

   // Lowest pending index wins
   function automatic logic [3:0] first_set(input logic [NPRIM-1:0] vec);
      logic [3:0] idx;
      idx = 4'h0;
      for (int k = NPRIM - 1; k >= 0; k--)
      begin
         if (vec[k])
         begin
            idx = 4'(k);
         end
      end
      return idx;
   endfunction

   // One-hot slot for a vector index
   function automatic logic [NPRIM-1:0] slot_of(input logic [3:0] idx);
      logic [NPRIM-1:0] onehot;
      onehot = '0;
      for (int k = 0; k < NPRIM; k++)
      begin
         if (idx == 4'(k))
         begin
            onehot[k] = 1'b1;
         end
      end
      return onehot;
   endfunction

   // Register write hit
   function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] target);
      return wr & (addr == target);
   endfunction

   // State
   logic [1:0] pin0_edge_code_ff;
   logic [1:0] pin1_edge_code_ff;
   logic global_irq_enable_ff;
   logic [NPRIM-1:0] prim_req_ff;
   logic [NPRIM-1:0] prim_allow_ff;
   logic [NSRC-1:0] src_req_ff;
   logic [NSRC-1:0] src_allow_ff;
   logic [3:0] vector_ff;
   logic [7:0] rdata_ff;

   // Next values
   logic [1:0] nxt_pin0_edge_code;
   logic [1:0] nxt_pin1_edge_code;
   logic nxt_global_irq_enable;
   logic [NPRIM-1:0] nxt_prim_req;
   logic [NPRIM-1:0] nxt_prim_allow;
   logic [NSRC-1:0] nxt_src_req;
   logic [NSRC-1:0] nxt_src_allow;
   logic [3:0] nxt_vector;
   logic [7:0] nxt_rdata;

   // Decode and events
   logic [1:0] pin_raw;
   logic [1:0][1:0] pin_code;
   logic [1:0] pin_edge;
   logic hit_edge;
   logic hit_ctl0;
   logic hit_ctl1;
   logic hit_ctl2;
   logic hit_grp0;
   logic hit_grp1;
   logic hit_grp2;
   logic hit_grp3;
   logic [NPRIM-1:0] prim_wmask;
   logic [NPRIM-1:0] prim_req_wval;
   logic [NPRIM-1:0] prim_allow_wval;
   logic [NSRC-1:0] src_wmask;
   logic [NSRC-1:0] src_req_wval;
   logic [NSRC-1:0] src_allow_wval;
   logic [NSRC-1:0] src_evt;
   logic [NSRC-1:0] src_set;
   logic [NGRP-1:0] grp_set;
   logic [NPRIM-1:0] grp_set_slots;
   logic [NPRIM-1:0] prim_set;
   logic [NPRIM-1:0] pending;
   logic [NPRIM-1:0] pending_at_vec;
   logic ack_taken;
   logic [NPRIM-1:0] ack_clear;

   // External pins
   assign pin_raw = {i_pin1, i_pin0};
   assign pin_code[0] = pin0_edge_code_ff;
   assign pin_code[1] = pin1_edge_code_ff;

   generate
      for (genvar p = 0; p < 2; p++)
      begin : g_pin
         pin_edge_detect u_edge
         (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_pin(pin_raw[p]),
            .i_code(pin_code[p]),
            .o_edge(pin_edge[p])
         );
      end
   endgenerate

   // Register write decode
   assign hit_edge = wr_hit(i_reg_wr, i_reg_addr, ADDR_EDGE);
   assign hit_ctl0 = wr_hit(i_reg_wr, i_reg_addr, ADDR_CTL0);
   assign hit_ctl1 = wr_hit(i_reg_wr, i_reg_addr, ADDR_CTL1);
   assign hit_ctl2 = wr_hit(i_reg_wr, i_reg_addr, ADDR_CTL2);
   assign hit_grp0 = wr_hit(i_reg_wr, i_reg_addr, ADDR_GRP0);
   assign hit_grp1 = wr_hit(i_reg_wr, i_reg_addr, ADDR_GRP1);
   assign hit_grp2 = wr_hit(i_reg_wr, i_reg_addr, ADDR_GRP2);
   assign hit_grp3 = wr_hit(i_reg_wr, i_reg_addr, ADDR_GRP3);

   // Primary slots: 0..2 in control 0, 3..6 in control 1, 7..8 in control 2
   assign prim_wmask = {{2{hit_ctl2}}, {4{hit_ctl1}}, {3{hit_ctl0}}};
   assign prim_req_wval = {i_reg_wdata[FLAG_LSB +: 2],
                           i_reg_wdata[FLAG_LSB +: 4],
                           i_reg_wdata[CTL0_FLAG_LSB +: 3]};
   assign prim_allow_wval = {i_reg_wdata[ALLOW_LSB +: 2],
                             i_reg_wdata[ALLOW_LSB +: 4],
                             i_reg_wdata[CTL0_ALLOW_LSB +: 3]};

   // Group source slots: 0..1, 2..4, 5..6, 7..8
   assign src_wmask = {{2{hit_grp3}}, {2{hit_grp2}}, {3{hit_grp1}}, {2{hit_grp0}}};
   assign src_req_wval = {i_reg_wdata[FLAG_LSB +: 2],
                          i_reg_wdata[FLAG_LSB +: 2],
                          i_reg_wdata[FLAG_LSB +: 3],
                          i_reg_wdata[FLAG_LSB +: 2]};
   assign src_allow_wval = {i_reg_wdata[ALLOW_LSB +: 2],
                            i_reg_wdata[ALLOW_LSB +: 2],
                            i_reg_wdata[ALLOW_LSB +: 3],
                            i_reg_wdata[ALLOW_LSB +: 2]};

   // Group source events
   assign src_evt = {i_timer2_cmpa_evt, i_timer2_cmpp_evt, i_eeprom_evt, i_undervolt_evt,
                     i_timer1_cmpb_evt, i_timer1_cmpa_evt, i_timer1_cmpp_evt,
                     i_timer0_cmpa_evt, i_timer0_cmpp_evt};
   assign src_set = src_evt & SRC_IMPL;

   // A member flag becoming set under its own enable raises its group
   generate
      for (genvar g = 0; g < NGRP; g++)
      begin : g_grp
         assign grp_set[g] = |(src_set & src_allow_ff & GRP_MEMBERS[g]);
      end
   endgenerate

   assign grp_set_slots = slot_of(GRP_SLOT[0]) & {NPRIM{grp_set[0]}} |
                          slot_of(GRP_SLOT[1]) & {NPRIM{grp_set[1]}} |
                          slot_of(GRP_SLOT[2]) & {NPRIM{grp_set[2]}} |
                          slot_of(GRP_SLOT[3]) & {NPRIM{grp_set[3]}};

   assign prim_set = (grp_set_slots |
                      {2'b00, i_timebase1_evt, i_timebase0_evt, i_conv_done_evt, 2'b00, pin_edge}) &
                     PRIM_IMPL;

   // Vector request toward the CPU core
   // The vector lags the pending set by one cycle; the request tests the flag at
   // that vector, so a stale index never raises a request for a cleared source
   assign pending = prim_req_ff & prim_allow_ff;
   assign pending_at_vec = pending >> vector_ff;
   assign o_irq_req = global_irq_enable_ff & ~i_stack_full & pending_at_vec[0];
   assign o_irq_vector = vector_ff;
   assign o_global_irq_enable = global_irq_enable_ff;
   assign ack_taken = i_irq_ack & o_irq_req;
   // Servicing clears only the primary flag, member flags stay
   assign ack_clear = ack_taken ? slot_of(vector_ff) : '0;

   // Next state; a hardware set wins over a software or service clear
   assign nxt_prim_req = ((((prim_req_ff & ~prim_wmask) | (prim_req_wval & prim_wmask)) & ~ack_clear) |
                          prim_set) & PRIM_IMPL;
   assign nxt_prim_allow = ((prim_allow_ff & ~prim_wmask) | (prim_allow_wval & prim_wmask)) &
                           PRIM_IMPL;
   assign nxt_src_req = (((src_req_ff & ~src_wmask) | (src_req_wval & src_wmask)) | src_set) &
                        SRC_IMPL;
   assign nxt_src_allow = ((src_allow_ff & ~src_wmask) | (src_allow_wval & src_wmask)) &
                          SRC_IMPL;

   // Servicing drops the global enable, even against a write in the same cycle
   assign nxt_global_irq_enable = ack_taken ? 1'b0 :
                                  hit_ctl0 ? i_reg_wdata[GIE_BIT] : global_irq_enable_ff;

   assign nxt_pin0_edge_code = hit_edge ? i_reg_wdata[PIN0_CODE_LSB +: 2] : pin0_edge_code_ff;
   assign nxt_pin1_edge_code = hit_edge ? i_reg_wdata[PIN1_CODE_LSB +: 2] : pin1_edge_code_ff;

   assign nxt_vector = first_set(pending);

   // Read mux; unmapped index reads zero
   always_comb
   begin
      case (i_reg_addr)
         ADDR_EDGE:
         begin
            nxt_rdata = {4'h0, pin1_edge_code_ff, pin0_edge_code_ff};
         end
         ADDR_CTL0:
         begin
            nxt_rdata = {1'b0, prim_req_ff[2:0], prim_allow_ff[2:0], global_irq_enable_ff};
         end
         ADDR_CTL1:
         begin
            nxt_rdata = {prim_req_ff[6:3], prim_allow_ff[6:3]};
         end
         ADDR_CTL2:
         begin
            nxt_rdata = {2'b00, prim_req_ff[8:7], 2'b00, prim_allow_ff[8:7]};
         end
         ADDR_GRP0:
         begin
            nxt_rdata = {2'b00, src_req_ff[1:0], 2'b00, src_allow_ff[1:0]};
         end
         ADDR_GRP1:
         begin
            nxt_rdata = {1'b0, src_req_ff[4:2], 1'b0, src_allow_ff[4:2]};
         end
         ADDR_GRP2:
         begin
            nxt_rdata = {2'b00, src_req_ff[6:5], 2'b00, src_allow_ff[6:5]};
         end
         ADDR_GRP3:
         begin
            nxt_rdata = {2'b00, src_req_ff[8:7], 2'b00, src_allow_ff[8:7]};
         end
         default:
         begin
            nxt_rdata = REG_RESET;
         end
      endcase
   end

   assign o_reg_rdata = rdata_ff;

   // Edge codes and global enable
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin0_edge_code_ff <= EDGE_OFF;
         pin1_edge_code_ff <= EDGE_OFF;
         global_irq_enable_ff <= 1'b0;
      end
      else
      begin
         pin0_edge_code_ff <= nxt_pin0_edge_code;
         pin1_edge_code_ff <= nxt_pin1_edge_code;
         global_irq_enable_ff <= nxt_global_irq_enable;
      end
   end

   // Request flags and enables
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         prim_req_ff <= '0;
         prim_allow_ff <= '0;
         src_req_ff <= '0;
         src_allow_ff <= '0;
      end
      else
      begin
         prim_req_ff <= nxt_prim_req;
         prim_allow_ff <= nxt_prim_allow;
         src_req_ff <= nxt_src_req;
         src_allow_ff <= nxt_src_allow;
      end
   end

   // Registered vector and read data
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         vector_ff <= 4'h0;
         rdata_ff <= REG_RESET;
      end
      else
      begin
         vector_ff <= nxt_vector;
         rdata_ff <= nxt_rdata;
      end
   end

endmodule
`default_nettype wire

//--- include/irq_bank_pkg.sv
// Constants for the interrupt request flag and enable bank.
// Assumes an 8-bit register port driven by the CPU core on the single system clock.
`default_nettype none
package irq_bank_pkg;

   // Register index on the CPU register port
   localparam logic [3:0] ADDR_EDGE = 4'h0;
   localparam logic [3:0] ADDR_CTL0 = 4'h1;
   localparam logic [3:0] ADDR_CTL1 = 4'h2;
   localparam logic [3:0] ADDR_CTL2 = 4'h3;
   localparam logic [3:0] ADDR_GRP0 = 4'h4;
   localparam logic [3:0] ADDR_GRP1 = 4'h5;
   localparam logic [3:0] ADDR_GRP2 = 4'h6;
   localparam logic [3:0] ADDR_GRP3 = 4'h7;

   // Field positions
   localparam int PIN0_CODE_LSB = 0;
   localparam int PIN1_CODE_LSB = 2;
   localparam int GIE_BIT = 0;
   localparam int CTL0_FLAG_LSB = 4;
   localparam int CTL0_ALLOW_LSB = 1;
   localparam int FLAG_LSB = 4;
   localparam int ALLOW_LSB = 0;

   // Reset value of every register
   localparam logic [7:0] REG_RESET = 8'h00;

   // Edge selector codes
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Primary sources, in vector priority order (0 highest):
   // 0 pin0, 1 pin1, 2 group0, 3 group1, 4 conv done, 5 timebase0, 6 timebase1, 7 group2, 8 group3
   localparam int NPRIM = 9;
   // Group sources: 0 t0 cmpp, 1 t0 cmpa, 2 t1 cmpp, 3 t1 cmpa, 4 t1 cmpb,
   // 5 undervolt, 6 eeprom, 7 t2 cmpp, 8 t2 cmpa
   localparam int NSRC = 9;
   localparam int NGRP = 4;

   // Group membership and the primary slot each group drives
   localparam logic [NGRP-1:0][NSRC-1:0] GRP_MEMBERS = {9'h180, 9'h060, 9'h01C, 9'h003};
   localparam logic [NGRP-1:0][3:0] GRP_SLOT = {4'h8, 4'h7, 4'h3, 4'h2};

   // Device variants
   localparam int VAR_SMALL = 0;
   localparam int VAR_CMPB = 1;
   localparam int VAR_LARGE = 2;
   localparam logic [NPRIM-1:0] PRIM_IMPL_LARGE = 9'h1FF;
   localparam logic [NPRIM-1:0] PRIM_IMPL_SMALL = 9'h0FF;
   localparam logic [NSRC-1:0] SRC_IMPL_LARGE = 9'h1FF;
   localparam logic [NSRC-1:0] SRC_IMPL_CMPB = 9'h07F;
   localparam logic [NSRC-1:0] SRC_IMPL_SMALL = 9'h06F;

endpackage
`default_nettype wire

//--- core/pin_edge_detect.sv
// External interrupt pin synchroniser and active-edge detector.
// Assumes an asynchronous pin; emits a one-cycle pulse on the selected edge.
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect
   import irq_bank_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   input wire logic [1:0] i_code,
   output logic o_edge
);

   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic rise;
   logic fall;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= i_pin;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign rise = sync_ff & ~prev_ff;
   assign fall = ~sync_ff & prev_ff;

   // Off, rising, falling or both edges
   assign o_edge = ((i_code == EDGE_RISE) & rise) |
                   ((i_code == EDGE_FALL) & fall) |
                   ((i_code == EDGE_BOTH) & (rise | fall));

endmodule
`default_nettype wire

//--- tb/cpu_vector_taker.sv
// CPU core stand-in that takes the presented vector with a one-cycle acknowledge.
// Assumes the bank's request is a level that stands until it is acknowledged.
`timescale 1ns/100ps
`default_nettype none
module cpu_vector_taker
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [3:0] i_vector,
   input wire logic i_take,
   input wire logic i_slow,
   output logic o_ack,
   output logic [3:0] o_taken_vector,
   output logic [7:0] o_taken_cnt
);
   logic ack_ff;
   logic [1:0] wait_ff;
   logic [3:0] vec_ff;
   logic [7:0] cnt_ff;
   wire want_w = i_req && i_take && !ack_ff;
   wire ready_w = want_w && (wait_ff == (i_slow ? 2'h3 : 2'h0));
   assign o_ack = ack_ff;
   assign o_taken_vector = vec_ff;
   assign o_taken_cnt = cnt_ff;
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         ack_ff <= 1'b0;
         wait_ff <= 2'h0;
         vec_ff <= 4'h0;
         cnt_ff <= 8'h00;
      end
      else
      begin
         // Acknowledge only a request that is standing
         ack_ff <= ready_w;
         wait_ff <= (want_w && !ready_w) ? wait_ff + 2'h1 : 2'h0;
         if (ready_w)
         begin
            vec_ff <= i_vector;
            cnt_ff <= cnt_ff + 8'h01;
         end
      end
endmodule
`default_nettype wire

//--- tb/irq_flag_bank_chk.sv
// Concurrent checks on the bank's register port and vector request.
// Assumes it is bound to irq_flag_bank and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_bank_chk
   import irq_bank_pkg::*;
#(
   parameter int VARIANT = VAR_LARGE
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_stack_full,
   input wire logic i_irq_ack,
   input wire logic o_irq_req,
   input wire logic [3:0] o_irq_vector,
   input wire logic o_global_irq_enable
);
   localparam logic [3:0] VEC_MAX = (VARIANT == VAR_LARGE) ? 4'h8 : 4'h7;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   wire take_w = o_irq_req && i_irq_ack;
   wire ctl0_wr_w = i_reg_wr && (i_reg_addr == ADDR_CTL0);
   property p_req_gated;
      o_irq_req |-> o_global_irq_enable && !i_stack_full;
   endproperty
   a_req_gated: assert property (p_req_gated) else $error("request while gated");
   property p_ack_clears;
      take_w |=> !o_global_irq_enable && !o_irq_req;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("service left enable set");
   property p_gie_write;
      ctl0_wr_w && !take_w |=> o_global_irq_enable == $past(i_reg_wdata[0]);
   endproperty
   a_gie_write: assert property (p_gie_write) else $error("global enable write lost");
   property p_gie_hold;
      !ctl0_wr_w && !take_w |=> $stable(o_global_irq_enable);
   endproperty
   a_gie_hold: assert property (p_gie_hold) else $error("global enable changed alone");
   property p_unmapped;
      i_reg_addr[3] |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_edge_upper;
      i_reg_addr == ADDR_EDGE |=> o_reg_rdata[7:4] == 4'h0;
   endproperty
   a_edge_upper: assert property (p_edge_upper) else $error("edge select upper bits set");
   property p_grp_unimpl;
      (i_reg_addr == ADDR_GRP0) || (i_reg_addr == ADDR_GRP2) |=> o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[3:2] == 2'h0;
   endproperty
   a_grp_unimpl: assert property (p_grp_unimpl) else $error("group unused bits set");
   property p_ctl0_top;
      i_reg_addr == ADDR_CTL0 |=> !o_reg_rdata[7];
   endproperty
   a_ctl0_top: assert property (p_ctl0_top) else $error("control0 bit 7 set");
   property p_vec_range;
      o_irq_req |-> o_irq_vector <= VEC_MAX;
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector out of range");
   sequence s_ctl1_wr;
      i_reg_wr && i_reg_addr == ADDR_CTL1 ##1 !i_reg_wr && i_reg_addr == ADDR_CTL1;
   endsequence
   property p_ctl1_allow;
      s_ctl1_wr |=> o_reg_rdata[3:0] == $past(i_reg_wdata[3:0], 2);
   endproperty
   a_ctl1_allow: assert property (p_ctl1_allow) else $error("control1 enables wrong");
   c_take: cover property (take_w);
   c_stack: cover property (i_stack_full && o_global_irq_enable);
   c_unmapped: cover property (i_reg_addr[3]);
endmodule
`default_nettype wire

//--- tb/irq_flag_bank_tb.sv
// Self-checking bench for the interrupt flag and enable bank, large variant.
// Assumes the CPU stand-in model and the checker bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module irq_flag_bank_tb
   import irq_bank_pkg::*;
;
   localparam int VARIANT = VAR_LARGE;
   localparam logic [7:0] MASK [9] = '{8'h0F, 8'h7F, 8'hFF, 8'h33, 8'h33, 8'h77, 8'h33, 8'h33, 8'h00};
   localparam logic [3:0] EV_REG [12] = '{ADDR_CTL1, ADDR_CTL1, ADDR_CTL1, ADDR_GRP0, ADDR_GRP0, ADDR_GRP1,
      ADDR_GRP1, ADDR_GRP1, ADDR_GRP2, ADDR_GRP2, ADDR_GRP3, ADDR_GRP3};
   localparam int EV_BIT [12] = '{6, 7, 5, 4, 5, 4, 5, 6, 4, 5, 4, 5};
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic pin0 = 1'b0;
   logic pin1 = 1'b0;
   logic [11:0] evt = 12'h000;
   logic stack_full = 1'b0;
   logic take = 1'b0;
   logic slow = 1'b0;
   logic [7:0] rdata;
   logic ack;
   logic req;
   logic gie;
   logic [3:0] vec;
   logic [3:0] taken_vec;
   logic [7:0] taken_cnt;
   int failures = 0;
   int tests_run = 0;
   irq_flag_bank #(.VARIANT(VARIANT)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pin0(pin0), .i_pin1(pin1), .i_timebase0_evt(evt[0]),
      .i_timebase1_evt(evt[1]), .i_conv_done_evt(evt[2]), .i_timer0_cmpp_evt(evt[3]), .i_timer0_cmpa_evt(evt[4]),
      .i_timer1_cmpp_evt(evt[5]), .i_timer1_cmpa_evt(evt[6]), .i_timer1_cmpb_evt(evt[7]), .i_undervolt_evt(evt[8]),
      .i_eeprom_evt(evt[9]), .i_timer2_cmpp_evt(evt[10]), .i_timer2_cmpa_evt(evt[11]), .i_stack_full(stack_full),
      .i_irq_ack(ack), .o_irq_req(req), .o_irq_vector(vec), .o_global_irq_enable(gie));
   cpu_vector_taker cpu (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_vector(vec), .i_take(take),
      .i_slow(slow), .o_ack(ack), .o_taken_vector(taken_vec), .o_taken_cnt(taken_cnt));
   initial forever #20 i_clk = ~i_clk;
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic reg_chk(input logic [3:0] a, input logic [7:0] ex);
      addr = a;
      tick(1);
      `CHK($sformatf("reg %0h", a), ex, rdata)
   endtask
   task automatic pulse(input int i);
      evt[i] = 1'b1;
      tick(1);
      evt[i] = 1'b0;
   endtask
   task automatic wait_take(input logic [7:0] n);
      int k;
      k = 0;
      while (taken_cnt !== n && k < 20)
      begin
         tick(1);
         k++;
      end
      `CHK("take count", n, taken_cnt)
      if (taken_cnt !== n)
         tally_and_finish();
      tick(2);
   endtask
   task automatic t_regs();
      logic [3:0] a;
      for (int i = 0; i < 9; i++)
      begin
         a = (i == 8) ? 4'hF : 4'(i);
         reg_chk(a, 8'h00);
         reg_wr(a, 8'hFF);
         reg_chk(a, MASK[i]);
         reg_wr(a, 8'h00);
      end
      $display("t_regs done");
   endtask
   task automatic t_events();
      for (int i = 0; i < 12; i++)
      begin
         pulse(i);
         reg_chk(EV_REG[i], 8'(1 << EV_BIT[i]));
         reg_wr(EV_REG[i], 8'h00);
         reg_chk(EV_REG[i], 8'h00);
      end
      reg_chk(ADDR_CTL2, 8'h00);
      $display("t_events done");
   endtask
   task automatic t_pins();
      logic [1:0] code;
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 4; c++)
         begin
            code = 2'(c);
            reg_wr(ADDR_EDGE, 8'(c << (2 * p)));
            if (p == 0)
               pin0 = 1'b1;
            else
               pin1 = 1'b1;
            tick(5);
            reg_chk(ADDR_CTL0, 8'(code[0] << (4 + p)));
            reg_wr(ADDR_CTL0, 8'h00);
            pin0 = 1'b0;
            pin1 = 1'b0;
            tick(5);
            reg_chk(ADDR_CTL0, 8'(code[1] << (4 + p)));
            reg_wr(ADDR_CTL0, 8'h00);
         end
      $display("t_pins done");
   endtask
   task automatic t_service();
      take = 1'b1;
      reg_wr(ADDR_GRP0, 8'h02);
      reg_wr(ADDR_CTL0, 8'h09);
      pulse(4);
      wait_take(8'h01);
      `CHK("vector", 4'h2, taken_vec)
      reg_chk(ADDR_CTL0, 8'h08);
      reg_chk(ADDR_GRP0, 8'h22);
      reg_wr(ADDR_GRP0, 8'h00);
      reg_wr(ADDR_CTL1, 8'h02);
      pulse(2);
      pulse(0);
      reg_chk(ADDR_CTL1, 8'h62);
      `CHK("request", 1'b0, req)
      slow = 1'b1;
      stack_full = 1'b1;
      reg_wr(ADDR_CTL0, 8'h01);
      tick(4);
      `CHK("request", 1'b0, req)
      stack_full = 1'b0;
      wait_take(8'h02);
      `CHK("vector", 4'h4, taken_vec)
      reg_chk(ADDR_CTL1, 8'h42);
      reg_wr(ADDR_CTL0, 8'h01);
      tick(4);
      `CHK("request", 1'b0, req)
      `CHK("global enable", 1'b1, gie)
      $display("t_service done");
   endtask
   initial
   begin
      repeat (8) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      t_regs();
      t_events();
      t_pins();
      t_service();
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge i_clk);
      failures++;
      $display("ERROR run timeout expected end seen hang");
      tally_and_finish();
   end
endmodule
bind irq_flag_bank irq_flag_bank_chk #(.VARIANT(VARIANT)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .i_stack_full(i_stack_full), .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector),
   .o_global_irq_enable(o_global_irq_enable));
`default_nettype wire
